// ### rtl/pmer_pkg.sv
// Package with the register map, field layout and carrier types of the event and reset bank.
package pmer_pkg;

    // ----------------------------------------
    // Bus geometry
    // ----------------------------------------
    localparam int unsigned PMER_ADDR_W = 10;
    localparam int unsigned PMER_DATA_W = 32;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [9:0] PMER_OFS_PPC = 10'h004;
    localparam logic [9:0] PMER_OFS_IEN_SET = 10'h0c0;
    localparam logic [9:0] PMER_OFS_IEN_CLR = 10'h0c4;
    localparam logic [9:0] PMER_OFS_MASK = 10'h0c8;
    localparam logic [9:0] PMER_OFS_PEND = 10'h0cc;
    localparam logic [9:0] PMER_OFS_PEND_CLR = 10'h0d0;
    localparam logic [9:0] PMER_OFS_FLAGS = 10'h0d4;
    localparam logic [9:0] PMER_OFS_CAUSE = 10'h180;

    // ----------------------------------------
    // Event flag positions and reset values
    // ----------------------------------------
    localparam int unsigned PMER_BIT_FAULT = 31;
    localparam int unsigned PMER_BIT_SWITCH = 5;
    localparam int unsigned PMER_BIT_FAIL = 0;
    localparam logic [31:0] PMER_FLAG_BITS = 32'h8000_0021;
    localparam logic [31:0] PMER_RST_FLAGS = 32'h0000_0020;
    localparam logic [31:0] PMER_RST_MASK = 32'h0000_0000;
    localparam logic [31:0] PMER_RST_PEND = 32'h0000_0000;

    // ----------------------------------------
    // Peripheral power control layout
    // ----------------------------------------
    localparam int unsigned PMER_PPC_W = 9;
    localparam logic [8:0] PMER_RST_PPC = 9'h1fa;

    // ----------------------------------------
    // Reset cause bit positions
    // ----------------------------------------
    localparam int unsigned PMER_CAUSE_POR = 0;
    localparam int unsigned PMER_CAUSE_BOD = 1;
    localparam int unsigned PMER_CAUSE_EXT = 2;
    localparam int unsigned PMER_CAUSE_WDOG = 3;
    localparam int unsigned PMER_CAUSE_SLEEP = 6;
    localparam int unsigned PMER_CAUSE_DBGUNIT = 8;
    localparam int unsigned PMER_CAUSE_JTAG = 9;
    localparam int unsigned PMER_CAUSE_SPD = 12;
    localparam logic [31:0] PMER_RST_CAUSE = 32'h0000_0000;

    // ----------------------------------------
    // Carrier types
    // ----------------------------------------
    // Peripheral power control outputs, in register bit order (bit 0 last).
    typedef struct packed {
        logic [5:0] request_clock_enable;
        logic reset_pin_test_mode;
        logic force_slow_rc_out;
        logic reset_pin_pullup_off;
    } pmer_ppc_t;

    // Clock events from the neighbouring clock logic, one-cycle pulses.
    typedef struct packed {
        logic protected_write_fault;
        logic divider_select_written;
        logic clocks_settled;
        logic main_clock_fail;
    } pmer_clk_evt_t;

    // Reset source levels from the reset controller, stable after reset release.
    typedef struct packed {
        logic single_pin_debug_reset;
        logic jtag_reset;
        logic debug_unit_reset;
        logic sleep_reset;
        logic watchdog_reset;
        logic ext_reset;
        logic brownout_reset;
        logic poweron_reset;
    } pmer_rst_src_t;

endpackage

// ### rtl/pmer_regs.sv
// Event, mask, status, peripheral power control and reset cause register bank.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ns
// How it works
// - Writing ones to enable-set sets those mask bits, others kept; here only flag bits 31, 5 and 0 can be set.
// - Writing ones to disable-set clears those mask bits, others kept.
// - Zero bits in enable-set, disable-set or pending-clear change nothing.
// - The mask register is read-only and shows which interrupts are enabled.
// - A pending bit sets on a rising status bit and stays until cleared.
// - Writing one to pending-clear clears the matching pending bit.
// - Status bit 31 sets on a write to a locked register without unlock.
// - Status bit 5 drops on a divider write, rises when clocks settle, resets one.
// - Status bit 0 sets on main clock failure; clock moves to system RC.
// - Control bit 0 turns the reset pin pull-up off when one.
// - Control bit 1 forces the slow RC signal out when one.
// - Control bit 2 puts the reset input into test mode when one.
// - Control bits 3 to 8 enable six module request clocks.
// - Cause bit 12 shows a reset from the single-pin debug interface.
// - Cause bit 9 shows a reset from the JTAG port.
// - Cause bit 8 shows a reset from the debug unit reset request.
// - Cause bit 3 shows a reset from watchdog timeout.
// - Cause bit 6 shows a reset from waking out of shutdown sleep.
module pmer_regs
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [pmer_pkg::PMER_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [pmer_pkg::PMER_DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [pmer_pkg::PMER_DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire pmer_pkg::pmer_clk_evt_t clk_evt,
    input wire pmer_pkg::pmer_rst_src_t rst_src,
    output pmer_pkg::pmer_ppc_t periph_ctl,
    output logic run_on_system_rc,
    output logic irq
);
    import pmer_pkg::*;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [31:0] mask_reg;
    logic [31:0] pending_reg;
    logic [31:0] flags_reg;
    logic [31:0] flags_prev_reg;
    logic [31:0] cause_reg;
    logic [PMER_PPC_W-1:0] ppc_reg;
    logic [31:0] readdata_reg;
    logic wait_reg;
    logic cap_done_reg;
    logic sysrc_reg;
    logic irq_reg;
    logic wr_go;
    logic [31:0] wbits;
    logic [31:0] lanes;
    logic [31:0] rd_next;
    logic [31:0] flags_rise;

    // Expands byte enables into a bit mask of written lanes.
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
        begin
            m[8*i +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    // ----------------------------------------
    // Avalon-MM handshake
    // ----------------------------------------
    // The slave idles with waitrequest high; one cycle after a request it
    // drops waitrequest for exactly one cycle, so every access takes two edges.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            wait_reg <= 1'b1;
        else if ((read || write) && wait_reg)
            wait_reg <= 1'b0;
        else
            wait_reg <= 1'b1;
    end

    // A write takes effect only at the edge where waitrequest is seen low.
    assign wr_go = write && !wait_reg;
    // Lane mask is kept as a net so the power control write can slice it.
    assign lanes = lane_mask(byteenable);
    assign wbits = writedata & lanes;

    // Read multiplexer; write-only and unmapped words read as zero.
    always_comb
    begin
        rd_next = 32'h0000_0000;
        case (address & ~10'h003)
            PMER_OFS_PPC: rd_next = {23'h000000, ppc_reg};
            PMER_OFS_MASK: rd_next = mask_reg;
            PMER_OFS_PEND: rd_next = pending_reg;
            PMER_OFS_FLAGS: rd_next = flags_reg;
            PMER_OFS_CAUSE: rd_next = cause_reg;
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // Read data is loaded while waitrequest is high and stands at the taking edge.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            readdata_reg <= 32'h0000_0000;
        else if (read && wait_reg)
            readdata_reg <= rd_next;
    end

    // ----------------------------------------
    // Interrupt mask
    // ----------------------------------------
    // Set and clear words only touch bits written as one; the mask offset
    // itself has no write path.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            mask_reg <= PMER_RST_MASK;
        else if (wr_go && (address & ~10'h003) == PMER_OFS_IEN_SET)
            mask_reg <= mask_reg | (wbits & PMER_FLAG_BITS);
        else if (wr_go && (address & ~10'h003) == PMER_OFS_IEN_CLR)
            mask_reg <= mask_reg & ~wbits;
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    // Hardware-owned flags; bus writes to this offset are dropped.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            flags_reg <= PMER_RST_FLAGS;
        else
        begin
            if (clk_evt.protected_write_fault)
                flags_reg[PMER_BIT_FAULT] <= 1'b1;
            // A new divider write restarts the switch even if settling coincides.
            if (clk_evt.divider_select_written)
                flags_reg[PMER_BIT_SWITCH] <= 1'b0;
            else if (clk_evt.clocks_settled)
                flags_reg[PMER_BIT_SWITCH] <= 1'b1;
            if (clk_evt.main_clock_fail)
                flags_reg[PMER_BIT_FAIL] <= 1'b1;
        end
    end

    // Switch-over request to the system RC oscillator after a clock failure.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            sysrc_reg <= 1'b0;
        else if (clk_evt.main_clock_fail)
            sysrc_reg <= 1'b1;
    end

    // ----------------------------------------
    // Pending flags
    // ----------------------------------------
    // Previous flags start at the reset value so the reset state is no edge.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            flags_prev_reg <= PMER_RST_FLAGS;
        else
            flags_prev_reg <= flags_reg;
    end

    assign flags_rise = flags_reg & ~flags_prev_reg;

    // A rising flag wins over a clear in the same cycle, so no event is lost.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pending_reg <= PMER_RST_PEND;
        else if (wr_go && (address & ~10'h003) == PMER_OFS_PEND_CLR)
            pending_reg <= (pending_reg & ~wbits) | flags_rise;
        else
            pending_reg <= pending_reg | flags_rise;
    end

    // Interrupt request is registered, one cycle behind the pending state.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(pending_reg & mask_reg);
    end

    // ----------------------------------------
    // Peripheral power control
    // ----------------------------------------
    // Only the nine implemented bits are stored; the rest read as zero.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ppc_reg <= PMER_RST_PPC;
        else if (wr_go && (address & ~10'h003) == PMER_OFS_PPC)
            ppc_reg <= (ppc_reg & ~lanes[8:0]) | wbits[8:0];
    end

    // ----------------------------------------
    // Reset cause
    // ----------------------------------------
    // Sources are caught at the first edge after reset release, never by the
    // reset itself, and then held until the next reset.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            cap_done_reg <= 1'b0;
        else
            cap_done_reg <= 1'b1;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            cause_reg <= PMER_RST_CAUSE;
        else if (!cap_done_reg)
        begin
            cause_reg <= 32'h0000_0000;
            cause_reg[PMER_CAUSE_POR] <= rst_src.poweron_reset;
            cause_reg[PMER_CAUSE_BOD] <= rst_src.brownout_reset;
            cause_reg[PMER_CAUSE_EXT] <= rst_src.ext_reset;
            cause_reg[PMER_CAUSE_WDOG] <= rst_src.watchdog_reset;
            cause_reg[PMER_CAUSE_SLEEP] <= rst_src.sleep_reset;
            cause_reg[PMER_CAUSE_DBGUNIT] <= rst_src.debug_unit_reset;
            cause_reg[PMER_CAUSE_JTAG] <= rst_src.jtag_reset;
            cause_reg[PMER_CAUSE_SPD] <= rst_src.single_pin_debug_reset;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Every output is a flip-flop; control bits map one to one.
    assign periph_ctl = pmer_ppc_t'(ppc_reg);
    assign readdata = readdata_reg;
    assign waitrequest = wait_reg;
    assign run_on_system_rc = sysrc_reg;
    assign irq = irq_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    AST_ENABLE_SET: assert property (
        wr_go && (address & ~10'h003) == PMER_OFS_IEN_SET
        |=> mask_reg == ($past(mask_reg) | ($past(wbits) & PMER_FLAG_BITS)))
        else $error("Enable-set did not set the written mask bits.");

    AST_DISABLE_SET: assert property (
        wr_go && (address & ~10'h003) == PMER_OFS_IEN_CLR
        |=> mask_reg == ($past(mask_reg) & ~$past(wbits)))
        else $error("Disable-set did not clear the written mask bits.");

    AST_ZERO_WRITE: assert property (
        wr_go && wbits == 32'h0000_0000
        |=> $stable(mask_reg) && ((~pending_reg & $past(pending_reg)) == 32'h0000_0000))
        else $error("A write of zeros changed mask or pending state.");

    AST_MASK_READ: assert property (
        read && wait_reg && (address & ~10'h003) == PMER_OFS_MASK
        |=> !waitrequest && readdata == $past(mask_reg))
        else $error("Mask read returned wrong data or timing.");

    AST_PEND_SET: assert property (
        flags_rise != 32'h0000_0000
        |=> (pending_reg & $past(flags_rise)) == $past(flags_rise))
        else $error("A rising status flag did not set its pending bit.");

    AST_PEND_CLR: assert property (
        wr_go && (address & ~10'h003) == PMER_OFS_PEND_CLR && flags_rise == 32'h0000_0000
        |=> (pending_reg & $past(wbits)) == 32'h0000_0000)
        else $error("Pending-clear did not clear the written bits.");

    AST_FAULT_FLAG: assert property (
        clk_evt.protected_write_fault && !flags_reg[PMER_BIT_FAULT]
        |=> flags_reg[PMER_BIT_FAULT] ##1 pending_reg[PMER_BIT_FAULT])
        else $error("Protected-write fault did not reach status and pending.");

    AST_SWITCH_DONE: assert property (
        clk_evt.divider_select_written |=> !flags_reg[PMER_BIT_SWITCH])
        else $error("Clock-switch-done did not drop on a divider write.");

    AST_CLOCK_FAIL: assert property (
        clk_evt.main_clock_fail |=> flags_reg[PMER_BIT_FAIL] && run_on_system_rc)
        else $error("Clock failure did not set the flag and RC switch-over.");

    AST_PPC_WRITE: assert property (
        wr_go && (address & ~10'h003) == PMER_OFS_PPC && byteenable[1:0] == 2'h3
        |=> periph_ctl == pmer_ppc_t'($past(writedata[8:0])))
        else $error("Peripheral control outputs do not follow the written word.");

    AST_IRQ: assert property (
        |(pending_reg & mask_reg) |=> irq ##0 $past(pending_reg & mask_reg) != 32'h0000_0000)
        else $error("Interrupt output not raised for an enabled pending bit.");

    AST_RO_MASK: assert property (
        wr_go && (address & ~10'h003) == PMER_OFS_MASK |=> $stable(mask_reg))
        else $error("A write to the read-only mask changed it.");

    AST_CAUSE: assert property (
        $rose(cap_done_reg)
        |-> cause_reg[PMER_CAUSE_SPD] == $past(rst_src.single_pin_debug_reset)
            && cause_reg[PMER_CAUSE_JTAG] == $past(rst_src.jtag_reset))
        else $error("Reset cause was not captured after reset release.");

    AST_BUS_ANSWER: assert property (
        (read || write) && wait_reg |=> !waitrequest ##1 waitrequest)
        else $error("Bus answer not given in exactly one cycle.");

    AST_NO_IRQ: assert property (
        (pending_reg & mask_reg) == 32'h0000_0000 |=> !irq)
        else $error("Interrupt output raised with no enabled pending bit.");

    AST_PEND_HOLD: assert property (
        !(wr_go && (address & ~10'h003) == PMER_OFS_PEND_CLR)
        |=> ($past(pending_reg) & ~pending_reg) == 32'h0000_0000)
        else $error("A pending bit fell without a pending-clear write.");

    AST_RO_STATUS: assert property (
        wr_go && (address & ~10'h003) == PMER_OFS_FLAGS && clk_evt == '0
        |=> $stable(flags_reg))
        else $error("A write to the read-only status changed it.");

    AST_RO_CAUSE: assert property (
        cap_done_reg |=> $stable(cause_reg))
        else $error("Reset cause changed after it was captured.");

    AST_CAUSE_LOCAL: assert property (
        $rose(cap_done_reg)
        |-> cause_reg[PMER_CAUSE_DBGUNIT] == $past(rst_src.debug_unit_reset)
            && cause_reg[PMER_CAUSE_WDOG] == $past(rst_src.watchdog_reset)
            && cause_reg[PMER_CAUSE_SLEEP] == $past(rst_src.sleep_reset))
        else $error("Debug, watchdog or sleep reset cause not captured.");

    AST_PPC_LOW_LANE: assert property (
        wr_go && (address & ~10'h003) == PMER_OFS_PPC && byteenable[0]
        |=> periph_ctl.force_slow_rc_out == $past(writedata[1])
            && periph_ctl.reset_pin_test_mode == $past(writedata[2])
            && periph_ctl.request_clock_enable[4:0] == $past(writedata[7:3]))
        else $error("Low lane of peripheral control not applied to the outputs.");

    AST_PPC_HIGH_LANE: assert property (
        wr_go && (address & ~10'h003) == PMER_OFS_PPC && byteenable[1]
        |=> periph_ctl.request_clock_enable[5] == $past(writedata[8]))
        else $error("High lane of peripheral control not applied to the outputs.");

    AST_SWITCH_BACK: assert property (
        clk_evt.clocks_settled && !clk_evt.divider_select_written
        |=> flags_reg[PMER_BIT_SWITCH])
        else $error("Clock-switch-done did not rise once the clocks settled.");

    AST_FAIL_STICKY: assert property (
        flags_reg[PMER_BIT_FAIL] |=> flags_reg[PMER_BIT_FAIL] && run_on_system_rc)
        else $error("Clock failure flag or RC switch-over was lost.");

    CV_IRQ: cover property (clk_evt.main_clock_fail ##[1:20] irq);
    CV_PEND_CLEAR: cover property (
        pending_reg != 32'h0000_0000 ##1 wr_go && (address & ~10'h003) == PMER_OFS_PEND_CLR);
    CV_PPC_WRITE: cover property (wr_go && (address & ~10'h003) == PMER_OFS_PPC);
    CV_CAUSE_READ: cover property (read && !wait_reg && (address & ~10'h003) == PMER_OFS_CAUSE);
    CV_SWITCH: cover property (clk_evt.divider_select_written ##[1:20] flags_reg[PMER_BIT_SWITCH]);

endmodule

// ### testbench/test_pmer_regs.sv
// Self-checking bench for the event, mask, power control and reset cause register bank.
`timescale 1ns/1ns
module test_pmer_regs;
    import pmer_pkg::*;

    // ----------------------------------------
    // Signals and counters
    // ----------------------------------------
    logic clk;
    logic resetn;
    logic [PMER_ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [PMER_DATA_W-1:0] writedata;
    logic [3:0] byteenable;
    logic [PMER_DATA_W-1:0] readdata;
    logic waitrequest;
    pmer_clk_evt_t clk_evt;
    pmer_rst_src_t rst_src;
    pmer_ppc_t periph_ctl;
    logic run_on_system_rc;
    logic irq;
    int n_mismatch;
    int checks;

    pmer_regs pmer_regs_inst (.clk(clk), .resetn(resetn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .clk_evt(clk_evt), .rst_src(rst_src),
        .periph_ctl(periph_ctl), .run_on_system_rc(run_on_system_rc), .irq(irq));

    // The 25 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // Compares a seen value with the expected one and reports a difference.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic finish_test();
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One bus access; the request stands until waitrequest is sampled low.
    task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= ~wr;
        write <= wr;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitrequest !== 1'b0);
        check(n, 32'h2, "bus answer edges");
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
        logic [31:0] q;
        xfer(1'b1, a, d, be, q);
    endtask

    task automatic rd_check(input logic [9:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, 4'hf, q);
        check(q, exp, what);
    endtask

    // One-cycle clock event, then time for flag, pending and interrupt to follow.
    task automatic pulse(input pmer_clk_evt_t e);
        @(posedge clk);
        clk_evt <= e;
        @(posedge clk);
        clk_evt <= '0;
        repeat (4) @(posedge clk);
    endtask

    // Holds reset for four cycles with the given reset source levels.
    task automatic do_reset(input pmer_rst_src_t src);
        @(posedge clk);
        resetn <= 1'b0;
        rst_src <= src;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        resetn = 1'b0;
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = '0;
        byteenable = '0;
        clk_evt = '0;
        rst_src = '0;
        n_mismatch = 0;
        checks = 0;
        // Debug pin, JTAG, debug unit, sleep and watchdog sources at once.
        do_reset(8'b1111_1000);
        check({23'h0, periph_ctl}, 32'h0000_01fa, "ppc pins at reset");
        rd_check(PMER_OFS_PPC, 32'h0000_01fa, "ppc reset");
        rd_check(PMER_OFS_FLAGS, 32'h0000_0020, "flags reset");
        rd_check(PMER_OFS_MASK, 32'h0, "mask reset");
        rd_check(PMER_OFS_PEND, 32'h0, "pending reset");
        rd_check(PMER_OFS_CAUSE, 32'h0000_1348, "cause");
        wr(PMER_OFS_CAUSE, 32'hffff_ffff);
        rd_check(PMER_OFS_CAUSE, 32'h0000_1348, "cause after write");
        // Mask set, clear and zero writes.
        wr(PMER_OFS_IEN_SET, 32'hffff_ffff);
        rd_check(PMER_OFS_MASK, 32'h8000_0021, "mask set");
        wr(PMER_OFS_IEN_CLR, 32'h0000_0020);
        rd_check(PMER_OFS_MASK, 32'h8000_0001, "mask clear");
        wr(PMER_OFS_IEN_SET, 32'h0);
        wr(PMER_OFS_IEN_CLR, 32'h0);
        wr(PMER_OFS_MASK, 32'h0);
        rd_check(PMER_OFS_MASK, 32'h8000_0001, "mask zero writes");
        // Main clock failure.
        pulse(4'b0001);
        check({31'h0, run_on_system_rc}, 32'h1, "system rc");
        check({31'h0, irq}, 32'h1, "irq fail");
        rd_check(PMER_OFS_FLAGS, 32'h0000_0021, "flags fail");
        rd_check(PMER_OFS_PEND, 32'h0000_0001, "pending fail");
        wr(PMER_OFS_PEND_CLR, 32'h0);
        wr(PMER_OFS_PEND, 32'h0);
        wr(PMER_OFS_FLAGS, 32'h0);
        rd_check(PMER_OFS_PEND, 32'h0000_0001, "pending zero clear");
        rd_check(PMER_OFS_FLAGS, 32'h0000_0021, "flags after write");
        wr(PMER_OFS_PEND_CLR, 32'h0000_0001);
        rd_check(PMER_OFS_PEND, 32'h0, "pending cleared");
        check({31'h0, irq}, 32'h0, "irq cleared");
        // A repeated failure is no new rising flag.
        pulse(4'b0001);
        rd_check(PMER_OFS_PEND, 32'h0, "pending no edge");
        // Clock switch: flag falls on the divider write and rises when settled.
        pulse(4'b0100);
        rd_check(PMER_OFS_FLAGS, 32'h0000_0001, "switch started");
        pulse(4'b0010);
        rd_check(PMER_OFS_FLAGS, 32'h0000_0021, "switch done");
        rd_check(PMER_OFS_PEND, 32'h0000_0020, "pending switch");
        check({31'h0, irq}, 32'h0, "irq masked");
        wr(PMER_OFS_IEN_SET, 32'h0000_0020);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h1, "irq unmasked");
        wr(PMER_OFS_PEND_CLR, 32'h0000_0020);
        // Protected write fault.
        pulse(4'b1000);
        rd_check(PMER_OFS_FLAGS, 32'h8000_0021, "fault flag");
        rd_check(PMER_OFS_PEND, 32'h8000_0000, "pending fault");
        check({31'h0, irq}, 32'h1, "irq fault");
        // Walking one through the power control bits.
        for (int i = 0; i < 9; i++)
        begin
            wr(PMER_OFS_PPC, 32'h1 << i);
            rd_check(PMER_OFS_PPC, 32'h1 << i, "ppc walk");
            check({23'h0, periph_ctl}, 32'h1 << i, "ppc pins");
        end
        wr(PMER_OFS_PPC, 32'hffff_ffff, 4'h1);
        rd_check(PMER_OFS_PPC, 32'h0000_01ff, "ppc low lane");
        wr(PMER_OFS_PPC, 32'h0, 4'h2);
        rd_check(PMER_OFS_PPC, 32'h0000_00ff, "ppc second lane");
        // Unmapped and write-only places read zero.
        rd_check(10'h3fc, 32'h0, "unmapped");
        rd_check(PMER_OFS_IEN_SET, 32'h0, "write-only");
        // Second reset with only brown-out and power-on sources.
        do_reset(8'b0000_0011);
        check({31'h0, run_on_system_rc}, 32'h0, "system rc after reset");
        rd_check(PMER_OFS_CAUSE, 32'h0000_0003, "cause again");
        rd_check(PMER_OFS_FLAGS, 32'h0000_0020, "flags again");
        rd_check(PMER_OFS_MASK, 32'h0, "mask again");
        rd_check(PMER_OFS_PPC, 32'h0000_01fa, "ppc again");
        finish_test();
    end

    // Cuts a hang short.
    initial
    begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end
endmodule
